// [common/hss_pkg.sv]
package hss_pkg;
  // Register indices, byte address is index * 4
  localparam logic [7:0] IDX_TMR1 = 8'h0c;
  localparam logic [7:0] IDX_TMR2 = 8'h0d;
  localparam logic [7:0] IDX_SHUT = 8'h10;
  localparam logic [7:0] IDX_SEL_LO = 8'h14;
  localparam logic [7:0] IDX_SEL_HI = 8'h15;
  localparam logic [7:0] IDX_MPIN = 8'h17;
  localparam logic [7:0] IDX_PWM_GENERATOR_ONE = 8'h18;
  localparam logic [7:0] IDX_PWM_GENERATOR_TWO = 8'h19;
  localparam logic [7:0] IDX_FREQ = 8'h1c;
  localparam logic [7:0] IDX_STAT = 8'h1f;
  // Writable bit masks, reserved bits read zero
  localparam logic [7:0] MSK_TMR = 8'h77;
  localparam logic [7:0] MSK_SHUT = 8'h70;
  localparam logic [7:0] MSK_SEL = 8'h77;
  localparam logic [7:0] MSK_FREQ = 8'h05;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Field positions
  localparam int OV_DIS_BIT = 6;
  localparam int UV_DIS_BIT = 5;
  localparam int REC_BIT = 4;
  localparam int FO_DUTY_LSB = 6;
  localparam int MP_TWO_LSB = 3;
  localparam int MP_ONE_LSB = 0;
  // Switch selector codes
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_ON = 3'h1;
  localparam logic [2:0] SEL_TMR1 = 3'h2;
  localparam logic [2:0] SEL_TMR2 = 3'h3;
  localparam logic [2:0] SEL_PWM_GENERATOR_ONE = 3'h4;
  localparam logic [2:0] SEL_PWM_GENERATOR_TWO = 3'h5;
  // Multipurpose pin codes
  localparam logic [2:0] MP_OFF = 3'h4;
  localparam logic [2:0] MP_WAKE = 3'h5;
  localparam logic [2:0] MP_LS_ON = 3'h6;
  localparam logic [2:0] MP_HS_ON = 3'h7;
  // Timer on-time codes that hold a level
  localparam logic [2:0] TON_LOW = 3'h0;
  localparam logic [2:0] TON_HIGH = 3'h6;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int PWM_PERIOD_200_NS = 5000000;
  localparam int PWM_STEPS = 255;
  localparam int PWM_STEP_CYCLES = PWM_PERIOD_200_NS / PWM_STEPS / CLK_PERIOD_NS;
  localparam logic [15:0] PWM_MAX = 16'h00ff;
  // Failure output waveform in 0.1 ms ticks
  localparam logic [5:0] FO_PERIOD_TICKS = 6'h28;
  localparam logic [5:0] FO_ON_20 = 6'h08;
  localparam logic [5:0] FO_ON_10 = 6'h04;
  localparam logic [5:0] FO_ON_5 = 6'h02;
  localparam logic [5:0] FO_ON_2P5 = 6'h01;
endpackage

// [dv/load_model.sv]
`timescale 1ns/1ps
// ==========================================
// Load bank on the four switch outputs
module load_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] hs_out,
  input wire logic [3:0] short_cmd,
  output logic [3:0] switch_fault
);
  // A shorted load flags overcurrent only while its switch drives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_fault <= 4'h0;
    end else begin
      switch_fault <= short_cmd & hs_out;
    end
  end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
// ==========================================
// Bench for the switch output control block
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic soft_reset = 1'b0;
  logic restart = 1'b0;
  logic fail_safe = 1'b0;
  logic [1:0] sup = 2'h0;
  logic [3:0] short_cmd = 4'h0;
  logic [3:0] switch_fault;
  logic [3:0] hs_out;
  logic [1:0] mp_hs_on;
  logic [1:0] mp_ls_on;
  logic [1:0] mp_wake_en;
  logic [31:0] rd_v;
  logic rd_e;
  int err_total = 0;
  int total_checks = 0;
  int cnt;
  int cnt2;
  logic [7:0] regs [5] = '{hss_pkg::IDX_SHUT, hss_pkg::IDX_SEL_LO, hss_pkg::IDX_SEL_HI,
                           hss_pkg::IDX_MPIN, hss_pkg::IDX_PWM_GENERATOR_ONE};
  logic [7:0] duty [3] = '{8'h00, 8'h80, 8'hff}; // No tiny nonzero duty

  // ==========================================
  // Clock and instances
  always #2 pclk = ~pclk;

  hss_ctrl #(.TICK_CYC(10), .PWM_STEP_CYC(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .restart(restart), .fail_safe(fail_safe),
    .supply_ov(sup[0]), .supply_uv(sup[1]), .switch_fault(switch_fault), .hs_out(hs_out),
    .mp_hs_on(mp_hs_on), .mp_ls_on(mp_ls_on), .mp_wake_en(mp_wake_en)
  );

  load_model load_u (
    .pclk(pclk), .presetn(presetn), .hs_out(hs_out), .short_cmd(short_cmd),
    .switch_fault(switch_fault)
  );

  // ==========================================
  // Verdict, compares and bus cycles
  task final_report;
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_cnt(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd_v, exp);
  endtask

  // Count high cycles of a switch and both pin drivers over a window
  task count_on(input int n, input int bitn);
    cnt = 0;
    cnt2 = 0;
    repeat (n) begin
      @(posedge pclk);
      cnt += (hs_out[bitn] === 1'b1 || mp_hs_on[0] === 1'b1) ? 1 : 0;
      cnt2 += (mp_hs_on[1] === 1'b1) ? 1 : 0;
    end
  endtask

  // Hang guard
  initial begin
    #200000;
    err_total++;
    final_report();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(regs[i], 32'h0);
    wr(hss_pkg::IDX_SHUT, 8'hff);
    rdc(hss_pkg::IDX_SHUT, 32'h70);
    wr(hss_pkg::IDX_SEL_LO, 8'hdd);
    rdc(hss_pkg::IDX_SEL_LO, 32'h55);
    wr(hss_pkg::IDX_SEL_HI, 8'hcd);
    rdc(hss_pkg::IDX_SEL_HI, 32'h45);
    wr(hss_pkg::IDX_SHUT, 8'h00);
    apb(1'b0, 8'h11, 8'h00);
    chk({31'h0, rd_e}, 32'h1);
    chk(rd_v, 32'h0);
    // Fixed on and off codes on all four outputs
    wr(hss_pkg::IDX_SEL_LO, 8'h10);
    wr(hss_pkg::IDX_SEL_HI, 8'h01);
    cyc(5);
    chk(hs_out, 32'h6);
    // Timers holding a level
    for (int k = 0; k < 2; k++) begin
      wr(8'(hss_pkg::IDX_TMR1 + k), {1'b0, hss_pkg::TON_HIGH, 4'h0});
      wr(hss_pkg::IDX_SEL_LO, {1'b0, 3'(hss_pkg::SEL_TMR1 + k), 1'b0, 3'(hss_pkg::SEL_TMR1 + k)});
      cyc(5);
      chk(hs_out[1:0], 32'h3);
      wr(8'(hss_pkg::IDX_TMR1 + k), {1'b0, hss_pkg::TON_LOW, 4'h0});
      cyc(5);
      chk(hs_out[1:0], 32'h0);
    end
    // Running timer: one tick on per 100 tick period, 10 of 1000 cycles
    wr(hss_pkg::IDX_TMR1, 8'h10);
    wr(hss_pkg::IDX_SEL_LO, {4'h0, 1'b0, hss_pkg::SEL_TMR1});
    cyc(1000);
    count_on(1000, 0);
    chk_cnt(cnt, 10, 2);
    // PWM one duty sweep, one period of 255 steps of 8 cycles
    wr(hss_pkg::IDX_SEL_LO, {4'h0, 1'b0, hss_pkg::SEL_PWM_GENERATOR_ONE});
    for (int i = 0; i < 3; i++) begin
      wr(hss_pkg::IDX_PWM_GENERATOR_ONE, duty[i]);
      cyc(2040);
      count_on(2040, 0);
      chk_cnt(cnt, 8 * int'(duty[i]), 16);
    end
    wr(hss_pkg::IDX_PWM_GENERATOR_TWO, 8'hff);
    wr(hss_pkg::IDX_SEL_LO, {4'h0, 1'b0, hss_pkg::SEL_PWM_GENERATOR_TWO});
    cyc(2040);
    chk(hs_out[0], 32'h1);
    // Supply faults: shutdown, suppression, recovery
    for (int k = 0; k < 2; k++) begin
      wr(hss_pkg::IDX_SHUT, 8'h00);
      wr(hss_pkg::IDX_SEL_LO, 8'h11);
      sup[k] <= 1'b1;
      cyc(6);
      chk(hs_out[1:0], 32'h0);
      sup[k] <= 1'b0;
      cyc(6);
      rdc(hss_pkg::IDX_SEL_LO, 32'h0);
      wr(hss_pkg::IDX_SHUT, 8'h40 >> k);
      wr(hss_pkg::IDX_SEL_LO, 8'h11);
      sup[k] <= 1'b1;
      cyc(6);
      chk(hs_out[1:0], 32'h3);
      sup[k] <= 1'b0;
      wr(hss_pkg::IDX_SHUT, 8'h10);
      sup[k] <= 1'b1;
      cyc(6);
      chk(hs_out[1:0], 32'h0);
      sup[k] <= 1'b0;
      cyc(6);
      chk(hs_out[1:0], 32'h3);
      rdc(hss_pkg::IDX_SEL_LO, 32'h11);
    end
    // Overcurrent on output three clears only its field
    wr(hss_pkg::IDX_SEL_HI, 8'h11);
    cyc(5);
    short_cmd <= 4'h4;
    cyc(8);
    short_cmd <= 4'h0;
    rdc(hss_pkg::IDX_SEL_HI, 32'h10);
    chk(hs_out, 32'hb);
    // Multipurpose pin codes
    wr(hss_pkg::IDX_MPIN, 8'h37);
    cyc(4);
    chk({mp_hs_on, mp_ls_on, mp_wake_en}, 32'h18);
    wr(hss_pkg::IDX_MPIN, 8'h25);
    cyc(4);
    chk({mp_hs_on, mp_ls_on, mp_wake_en}, 32'h01);
    // Failure output duty on both pins, 400 cycle period
    wr(hss_pkg::IDX_SEL_LO, 8'h00);
    fail_safe <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      wr(hss_pkg::IDX_MPIN, {d[1:0], 6'h00});
      cyc(400);
      count_on(400, 0);
      chk_cnt(cnt, (8 >> d) * 10, 3);
      chk_cnt(cnt2, (8 >> d) * 10, 3);
    end
    fail_safe <= 1'b0;
    // Restart keeps some registers, soft reset clears all
    wr(hss_pkg::IDX_SHUT, 8'h7f);
    wr(hss_pkg::IDX_SEL_LO, 8'h11);
    wr(hss_pkg::IDX_MPIN, 8'hc5);
    wr(hss_pkg::IDX_PWM_GENERATOR_ONE, 8'h3c);
    restart <= 1'b1;
    cyc(1);
    restart <= 1'b0;
    cyc(4);
    chk(hs_out, 32'h0);
    rdc(hss_pkg::IDX_SHUT, 32'h70);
    rdc(hss_pkg::IDX_SEL_LO, 32'h0);
    rdc(hss_pkg::IDX_SEL_HI, 32'h0);
    rdc(hss_pkg::IDX_MPIN, 32'hc5);
    rdc(hss_pkg::IDX_PWM_GENERATOR_ONE, 32'h3c);
    soft_reset <= 1'b1;
    cyc(1);
    soft_reset <= 1'b0;
    for (int i = 0; i < 5; i++) rdc(regs[i], 32'h0);
    final_report();
  end
endmodule

// [rtl/hss_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - Shutdown register bit 6 set suppresses overvoltage switch-off of all switches.
// - Shutdown register bit 5 set suppresses undervoltage switch-off of all switches.
// - Bit 4 set restores previous switch state after supply fault, else off.
// - Reserved bits in shutdown and selector registers read zero, ignore writes.
// - Selector 0 off, 1 on, 2/3 timers, 4/5 PWMs, 6/7 reserved.
// - Low pair register: output one in bits 2:0, two in 6:4.
// - High pair register: output three in bits 2:0, four in 6:4.
// - Overcurrent or overtemperature clears that output's selector to zero.
// - Pin register bits 7:6 set failure duty 20, 10, 5, 2.5 percent.
// - Pin two in bits 5:3: failure out, off, wake, low or high on.
// - Pin one in bits 2:0, same codes, driving second failure output.
// - PWM one on-fraction is duty/255; zero off, all ones on.
// - Power-on or soft reset clears all nine registers to zero.
// - Restart keeps shutdown bits 6:4, clears the rest.
// - Restart clears both selector registers, all outputs off.
// - Restart keeps pin register and PWM one duty.
// - Timer on-time code: low, 0.1 to 20 ms, high, reserved.
// - Timer period code: 10 ms up to 2 s, 111 reserved.
// - PWM frequency select bit: 0 gives 200 Hz, 1 gives 400 Hz.
module hss_ctrl #(
  parameter int TICK_CYC = hss_pkg::TICK_CYCLES,
  parameter int PWM_STEP_CYC = hss_pkg::PWM_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic fail_safe,
  input wire logic supply_ov,
  input wire logic supply_uv,
  input wire logic [3:0] switch_fault,
  output logic [3:0] hs_out,
  output logic [1:0] mp_hs_on,
  output logic [1:0] mp_ls_on,
  output logic [1:0] mp_wake_en
);
  // ==========================================
  // Input synchronisers
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {supply_ov, supply_uv, switch_fault};
      sync2_r <= sync1_r;
    end
  end
  logic ov_s;
  logic uv_s;
  logic [3:0] flt_s;
  assign ov_s = sync2_r[5];
  assign uv_s = sync2_r[4];
  assign flt_s = sync2_r[3:0];

  // ==========================================
  // APB decode
  logic [7:0] shut_r, sel_lo_r, sel_hi_r, mpin_r, pwm_generator_one_r, pwm_generator_two_r, freq_r;
  logic [7:0] tmr_r [2];
  logic [7:0] idx;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  assign idx = paddr[9:2];
  assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  // Map check
  always_comb begin
    if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0) mapped = 1'b0;
    else if (idx == hss_pkg::IDX_TMR1 || idx == hss_pkg::IDX_TMR2) mapped = 1'b1;
    else if (idx == hss_pkg::IDX_SHUT || idx == hss_pkg::IDX_SEL_LO) mapped = 1'b1;
    else if (idx == hss_pkg::IDX_SEL_HI || idx == hss_pkg::IDX_MPIN) mapped = 1'b1;
    else if (idx == hss_pkg::IDX_PWM_GENERATOR_ONE || idx == hss_pkg::IDX_PWM_GENERATOR_TWO) mapped = 1'b1;
    else if (idx == hss_pkg::IDX_FREQ || idx == hss_pkg::IDX_STAT) mapped = 1'b1;
    else mapped = 1'b0;
  end
  assign pslverr = psel && penable && !mapped;

  function automatic logic hit(input logic [7:0] i, input logic [7:0] r);
    hit = (i == r);
  endfunction

  // ==========================================
  // Supply fault shutdown
  logic shutdown;
  logic shut_onset;
  logic shut_d_r;
  assign shutdown = (ov_s && !shut_r[hss_pkg::OV_DIS_BIT])
    || (uv_s && !shut_r[hss_pkg::UV_DIS_BIT]);
  assign shut_onset = shutdown && !shut_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shut_d_r <= 1'b0;
    else shut_d_r <= shutdown;
  end
  logic sel_wipe;
  assign sel_wipe = shutdown && !shut_r[hss_pkg::REC_BIT];

  // ==========================================
  // Shutdown control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shut_r <= hss_pkg::RST_VAL;
    else if (soft_reset) shut_r <= hss_pkg::RST_VAL;
    else if (restart) shut_r <= shut_r & hss_pkg::MSK_SHUT;
    else if (wr_en && hit(idx, hss_pkg::IDX_SHUT))
      shut_r <= pwdata[7:0] & hss_pkg::MSK_SHUT;
  end

  // ==========================================
  // Selector registers, hardware clear beats a write
  logic [7:0] sel_lo_nxt, sel_hi_nxt;
  always_comb begin
    sel_lo_nxt = sel_lo_r;
    sel_hi_nxt = sel_hi_r;
    if (wr_en && hit(idx, hss_pkg::IDX_SEL_LO)) sel_lo_nxt = pwdata[7:0] & hss_pkg::MSK_SEL;
    if (wr_en && hit(idx, hss_pkg::IDX_SEL_HI)) sel_hi_nxt = pwdata[7:0] & hss_pkg::MSK_SEL;
    if (flt_s[0]) sel_lo_nxt[2:0] = hss_pkg::SEL_OFF;
    if (flt_s[1]) sel_lo_nxt[6:4] = hss_pkg::SEL_OFF;
    if (flt_s[2]) sel_hi_nxt[2:0] = hss_pkg::SEL_OFF;
    if (flt_s[3]) sel_hi_nxt[6:4] = hss_pkg::SEL_OFF;
    if (sel_wipe || soft_reset || restart) begin
      sel_lo_nxt = hss_pkg::RST_VAL;
      sel_hi_nxt = hss_pkg::RST_VAL;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lo_r <= hss_pkg::RST_VAL;
      sel_hi_r <= hss_pkg::RST_VAL;
    end else begin
      sel_lo_r <= sel_lo_nxt;
      sel_hi_r <= sel_hi_nxt;
    end
  end

  // ==========================================
  // Pin, duty and frequency registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mpin_r <= hss_pkg::RST_VAL;
      pwm_generator_one_r <= hss_pkg::RST_VAL;
      pwm_generator_two_r <= hss_pkg::RST_VAL;
      freq_r <= hss_pkg::RST_VAL;
    end else if (soft_reset) begin
      mpin_r <= hss_pkg::RST_VAL;
      pwm_generator_one_r <= hss_pkg::RST_VAL;
      pwm_generator_two_r <= hss_pkg::RST_VAL;
      freq_r <= hss_pkg::RST_VAL;
    end else if (!restart && wr_en) begin
      if (hit(idx, hss_pkg::IDX_MPIN)) mpin_r <= pwdata[7:0];
      else if (hit(idx, hss_pkg::IDX_PWM_GENERATOR_ONE)) pwm_generator_one_r <= pwdata[7:0];
      else if (hit(idx, hss_pkg::IDX_PWM_GENERATOR_TWO)) pwm_generator_two_r <= pwdata[7:0];
      else if (hit(idx, hss_pkg::IDX_FREQ)) freq_r <= pwdata[7:0] & hss_pkg::MSK_FREQ;
    end
  end

  // ==========================================
  // Base 0.1 ms tick
  logic [15:0] pre_r;
  logic tick;
  assign tick = (pre_r == 16'(TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_r <= 16'h0000;
    else if (tick) pre_r <= 16'h0000;
    else pre_r <= pre_r + 16'h0001;
  end

  function automatic logic [15:0] on_ticks(input logic [2:0] c);
    case (c)
      3'h1: on_ticks = 16'd1;
      3'h2: on_ticks = 16'd3;
      3'h3: on_ticks = 16'd10;
      3'h4: on_ticks = 16'd100;
      3'h5: on_ticks = 16'd200;
      default: on_ticks = 16'd0;
    endcase
  endfunction
  function automatic logic [15:0] per_ticks(input logic [2:0] c);
    case (c)
      3'h0: per_ticks = 16'd100;
      3'h1: per_ticks = 16'd200;
      3'h2: per_ticks = 16'd500;
      3'h3: per_ticks = 16'd1000;
      3'h4: per_ticks = 16'd2000;
      3'h5: per_ticks = 16'd10000;
      default: per_ticks = 16'd20000;
    endcase
  endfunction

  // ==========================================
  // Cyclic timers and PWM generators
  logic [1:0] tmr_out;
  logic [1:0] pwm_out;
  logic [7:0] duty [2];
  assign duty[0] = pwm_generator_one_r;
  assign duty[1] = pwm_generator_two_r;
  for (genvar g = 0; g < 2; g++) begin : g_gen
    logic [15:0] tcnt_r;
    logic [15:0] pcnt_r;
    logic [7:0] phase_r;
    logic [15:0] step;
    logic [2:0] ton;
    assign ton = tmr_r[g][6:4];
    // Timer settings, cleared on soft reset or restart
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tmr_r[g] <= hss_pkg::RST_VAL;
      else if (soft_reset || restart) tmr_r[g] <= hss_pkg::RST_VAL;
      else if (wr_en && hit(idx, g == 0 ? hss_pkg::IDX_TMR1 : hss_pkg::IDX_TMR2))
        tmr_r[g] <= pwdata[7:0] & hss_pkg::MSK_TMR;
    end
    // Timer phase in ticks
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tcnt_r <= 16'h0000;
      else if (ton == hss_pkg::TON_LOW || ton == hss_pkg::TON_HIGH) tcnt_r <= 16'h0000;
      else if (tick && tcnt_r >= per_ticks(tmr_r[g][2:0]) - 16'h0001) tcnt_r <= 16'h0000;
      else if (tick) tcnt_r <= tcnt_r + 16'h0001;
    end
    assign tmr_out[g] = (ton == hss_pkg::TON_HIGH) || (tcnt_r < on_ticks(ton));
    // PWM step prescaler, halved for 400 Hz
    assign step = freq_r[2 * g] ? 16'(PWM_STEP_CYC / 2 - 1) : 16'(PWM_STEP_CYC - 1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pcnt_r <= 16'h0000;
        phase_r <= 8'h00;
      end else if (pcnt_r >= step) begin
        pcnt_r <= 16'h0000;
        phase_r <= (phase_r >= 8'(hss_pkg::PWM_MAX - 16'h0001)) ? 8'h00 : phase_r + 8'h01;
      end else begin
        pcnt_r <= pcnt_r + 16'h0001;
      end
    end
    assign pwm_out[g] = (phase_r < duty[g]);
  end

  // ==========================================
  // Switch outputs
  function automatic logic src(input logic [2:0] s, input logic [1:0] t, input logic [1:0] p);
    case (s)
      hss_pkg::SEL_ON: src = 1'b1;
      hss_pkg::SEL_TMR1: src = t[0];
      hss_pkg::SEL_TMR2: src = t[1];
      hss_pkg::SEL_PWM_GENERATOR_ONE: src = p[0];
      hss_pkg::SEL_PWM_GENERATOR_TWO: src = p[1];
      default: src = 1'b0;
    endcase
  endfunction
  logic [3:0] hs_nxt;
  always_comb begin
    hs_nxt[0] = src(sel_lo_r[2:0], tmr_out, pwm_out);
    hs_nxt[1] = src(sel_lo_r[6:4], tmr_out, pwm_out);
    hs_nxt[2] = src(sel_hi_r[2:0], tmr_out, pwm_out);
    hs_nxt[3] = src(sel_hi_r[6:4], tmr_out, pwm_out);
    if (shutdown) hs_nxt = 4'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hs_out <= 4'h0;
    else hs_out <= hs_nxt;
  end

  // ==========================================
  // Failure output waveform and pins
  logic [5:0] fo_cnt_r;
  logic [5:0] fo_on;
  logic fo_wave;
  always_comb begin
    case (mpin_r[7:6])
      2'h0: fo_on = hss_pkg::FO_ON_20;
      2'h1: fo_on = hss_pkg::FO_ON_10;
      2'h2: fo_on = hss_pkg::FO_ON_5;
      default: fo_on = hss_pkg::FO_ON_2P5;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fo_cnt_r <= 6'h00;
    else if (tick && fo_cnt_r >= hss_pkg::FO_PERIOD_TICKS - 6'h01) fo_cnt_r <= 6'h00;
    else if (tick) fo_cnt_r <= fo_cnt_r + 6'h01;
  end
  assign fo_wave = fail_safe && (fo_cnt_r < fo_on);
  for (genvar m = 0; m < 2; m++) begin : g_mp
    logic [2:0] c;
    assign c = m == 0 ? mpin_r[2:0] : mpin_r[5:3];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mp_hs_on[m] <= 1'b0;
        mp_ls_on[m] <= 1'b0;
        mp_wake_en[m] <= 1'b0;
      end else begin
        mp_hs_on[m] <= (c == hss_pkg::MP_HS_ON) || (!c[2] && fo_wave);
        mp_ls_on[m] <= (c == hss_pkg::MP_LS_ON);
        mp_wake_en[m] <= (c == hss_pkg::MP_WAKE);
      end
    end
  end

  // ==========================================
  // Read data, captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (rd_setup) begin
      if (!mapped) prdata <= 32'h0;
      else if (hit(idx, hss_pkg::IDX_SHUT)) prdata <= {24'h0, shut_r};
      else if (hit(idx, hss_pkg::IDX_SEL_LO)) prdata <= {24'h0, sel_lo_r};
      else if (hit(idx, hss_pkg::IDX_SEL_HI)) prdata <= {24'h0, sel_hi_r};
      else if (hit(idx, hss_pkg::IDX_MPIN)) prdata <= {24'h0, mpin_r};
      else if (hit(idx, hss_pkg::IDX_PWM_GENERATOR_ONE)) prdata <= {24'h0, pwm_generator_one_r};
      else if (hit(idx, hss_pkg::IDX_PWM_GENERATOR_TWO)) prdata <= {24'h0, pwm_generator_two_r};
      else if (hit(idx, hss_pkg::IDX_TMR1)) prdata <= {24'h0, tmr_r[0]};
      else if (hit(idx, hss_pkg::IDX_TMR2)) prdata <= {24'h0, tmr_r[1]};
      else if (hit(idx, hss_pkg::IDX_FREQ)) prdata <= {24'h0, freq_r};
      else if (hit(idx, hss_pkg::IDX_STAT)) prdata <= {24'h0, ov_s, uv_s, shutdown, 1'b0, hs_out};
      else prdata <= 32'h0;
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ov;
    ov_s && !shut_r[6] |=> hs_out == 4'h0;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage did not switch off");
  property p_uv;
    uv_s && !shut_r[5] |=> hs_out == 4'h0;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage did not switch off");
  property p_onset;
    shut_onset |=> hs_out == 4'h0;
  endproperty
  a_onset: assert property (p_onset) else $error("outputs on after shutdown onset");
  property p_rec;
    shutdown && !shut_r[4] && !soft_reset |=> sel_lo_r == 8'h0 && sel_hi_r == 8'h0;
  endproperty
  a_rec: assert property (p_rec) else $error("selectors kept without recovery");
  property p_resv;
    shut_r[7] == 1'b0 && shut_r[3:0] == 4'h0 && (sel_lo_r & 8'h88) == 8'h00
      && (sel_hi_r & 8'h88) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_on;
    sel_lo_r[2:0] == 3'h1 && !shutdown |=> hs_out[0];
  endproperty
  a_on: assert property (p_on) else $error("output one not on");
  property p_flt;
    flt_s[2] |=> sel_hi_r[2:0] == 3'h0 ##1 !hs_out[2];
  endproperty
  a_flt: assert property (p_flt) else $error("fault did not clear selector");
  property p_pwm;
    pwm_generator_one_r == 8'hff |-> pwm_out[0];
  endproperty
  a_pwm: assert property (p_pwm) else $error("full duty not on");
  property p_rst;
    restart && !soft_reset |=> shut_r == ($past(shut_r) & 8'h70) && sel_lo_r == 8'h0
      && mpin_r == $past(mpin_r) && pwm_generator_one_r == $past(pwm_generator_one_r);
  endproperty
  a_rst: assert property (p_rst) else $error("restart values wrong");
  property p_soft;
    soft_reset |=> shut_r == 8'h0 && mpin_r == 8'h0 && pwm_generator_one_r == 8'h0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset did not clear");
endmodule
